// *** rtl/turnstile_contact_pkg.sv ***
package turnstile_contact_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ           = 50000000;
  localparam int TICK_DEFAULT     = CLK_HZ / 1000;  // cycles in one millisecond
  localparam int MS_W             = 13;
  localparam int MIN_CLOSE_MS     = 100;
  localparam int MAX_CLOSE_MS     = 2000;
  localparam int OUT_PULSE_MS     = 300;
  localparam int RED_LAMP_MS      = 2000;
  localparam int GRANT_TIMEOUT_MS = 5000;

  // ****************************************
  // synchronised pin vector layout
  // ****************************************
  localparam int N_PIN         = 9;
  localparam int N_MOM         = 4;
  localparam int MOM_GOOD_ENT  = 0;
  localparam int MOM_GOOD_EXT  = 1;
  localparam int MOM_BAD_ENT   = 2;
  localparam int MOM_OVR_ENT   = 3;
  localparam int SUS_FREE_ENT  = 4;
  localparam int SUS_CLOSE_ENT = 5;
  localparam int SUS_VISITOR   = 6;
  localparam int SUS_FIRE      = 7;
  localparam int SUS_FIRE_POL  = 8;
  localparam logic [N_PIN-1:0] PIN_RESET = 9'h000;

  // ****************************************
  // output contacts
  // ****************************************
  localparam int N_OUT          = 5;
  localparam int OUT_AUTH_ENT   = 0;
  localparam int OUT_UNAUTH_ENT = 1;
  localparam int OUT_INTR_ENT   = 2;
  localparam int OUT_AUTH_EXT   = 3;
  localparam int OUT_UNAUTH_EXT = 4;
  localparam int N_RESV         = 3;

  typedef enum logic [1:0] {MODE_CONTROLLED, MODE_FREE, MODE_CLOSED} dir_mode_e;
  typedef enum logic {GRANT_IDLE, GRANT_OPEN} grant_e;

endpackage

// *** rtl/turnstile_contact_io.sv ***
// Behaviour
// RULE1 - outside system closes normally open dry contacts, fire alarm excepted
// RULE2 - momentary closures shorter than 100 ms are ignored
// RULE3 - momentary closures up to 2 s are accepted, 1 s suggested
// RULE4 - each output is a 300 ms contact closure
// RULE5 - fire alarm polarity chosen by jumper, default normally open
// RULE6 - good card opens that direction for one passage until passage or timeout
// RULE7 - bad card on entry lights entry red lamp for 2 s
// RULE8 - closed free passage entry contact sets entry free passage mode
// RULE9 - closed close entry contact sets entry no passage mode
// RULE10 - single override on entry grants one entry passage
// RULE11 - visitor contact frees both directions and disables barrier
// RULE12 - authorized entry passage pulses authorized entry output once
// RULE13 - unauthorized entry passage pulses unauthorized entry output once
// RULE14 - unauthorized entry into lane from entry side pulses intrusion output
// RULE15 - authorized exit passage pulses authorized exit output once
// RULE16 - unauthorized exit passage pulses unauthorized exit output once
// RULE17 - every contact input is synchronised and debounced before use
// RULE18 - reserved outputs stay open; sustained modes last only while closed
module turnstile_contact_io
  import turnstile_contact_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DEFAULT
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            good_card_entry_in,
  input  wire logic            good_card_exit_in,
  input  wire logic            bad_card_entry_in,
  input  wire logic            single_override_entry_in,
  input  wire logic            free_passage_entry_in,
  input  wire logic            close_entry_in,
  input  wire logic            visitor_mode_in,
  input  wire logic            fire_alarm_in,
  input  wire logic            fire_alarm_polarity_jumper,
  input  wire logic            entry_pass_done,
  input  wire logic            exit_pass_done,
  input  wire logic            entry_lane_intrude,
  output logic                 authorized_entry_out,
  output logic                 unauthorized_entry_out,
  output logic                 entry_intrusion_out,
  output logic                 authorized_exit_out,
  output logic                 unauthorized_exit_out,
  output logic [N_RESV-1:0]    reserved_contacts_out,
  output logic                 entry_unlock,
  output logic                 exit_unlock,
  output logic                 entry_red_lamp,
  output dir_mode_e            entry_mode,
  output logic                 exit_free,
  output logic                 barrier_disable,
  output logic                 fire_alarm_active
);

  localparam int TW = $clog2(TICK_CYCLES);

  function automatic logic [MS_W-1:0] count_down(input logic [MS_W-1:0] v, input logic t);
    return (t && v != '0) ? v - 1'b1 : v;
  endfunction

  // ****************************************
  // millisecond tick
  // ****************************************
  logic [TW-1:0] tick_cnt_reg;
  logic          tick_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TW'(TICK_CYCLES - 1));
      if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) tick_cnt_reg <= '0;
      else tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [N_PIN-1:0] pin_w;
  logic [N_PIN-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;

  assign pin_w = {fire_alarm_polarity_jumper, fire_alarm_in, visitor_mode_in, close_entry_in,
                  free_passage_entry_in, single_override_entry_in, bad_card_entry_in,
                  good_card_exit_in, good_card_entry_in};

  // a level is taken only once the last two stages agree, so a bouncing edge is held off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg  <= PIN_RESET;
      s2_reg  <= PIN_RESET;
      s3_reg  <= PIN_RESET;
      lvl_reg <= PIN_RESET;
    end else begin
      s1_reg <= pin_w;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < N_PIN; i++) begin
        if (s2_reg[i] == s3_reg[i]) lvl_reg[i] <= s3_reg[i];  // see RULE17
      end
    end
  end

  // ****************************************
  // momentary closure length
  // ****************************************
  logic [MS_W-1:0]  hold_ms_reg [N_MOM];
  logic [N_MOM-1:0] mom_fire_reg;

  // fires once per closure after a full 100 ms; a long hold never refires
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mom_fire_reg <= '0;
      for (int i = 0; i < N_MOM; i++) hold_ms_reg[i] <= '0;
    end else begin
      for (int i = 0; i < N_MOM; i++) begin
        mom_fire_reg[i] <= lvl_reg[i] && tick_reg && hold_ms_reg[i] == MS_W'(MIN_CLOSE_MS);
        if (!lvl_reg[i]) hold_ms_reg[i] <= '0;  // see RULE2
        else if (tick_reg && hold_ms_reg[i] <= MS_W'(MIN_CLOSE_MS))
          hold_ms_reg[i] <= hold_ms_reg[i] + 1'b1;  // see RULE3
      end
    end
  end

  // ****************************************
  // passage modes
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_mode      <= MODE_CONTROLLED;
      exit_free       <= 1'b0;
      barrier_disable <= 1'b0;
    end else begin
      // close wins over free so a wiring fault fails safe
      if (lvl_reg[SUS_VISITOR]) entry_mode <= MODE_FREE;  // see RULE11
      else if (lvl_reg[SUS_CLOSE_ENT]) entry_mode <= MODE_CLOSED;  // see RULE9
      else if (lvl_reg[SUS_FREE_ENT]) entry_mode <= MODE_FREE;  // see RULE8
      else entry_mode <= MODE_CONTROLLED;  // see RULE18
      exit_free       <= lvl_reg[SUS_VISITOR];  // see RULE11
      barrier_disable <= lvl_reg[SUS_VISITOR];
    end
  end

  // jumper closed selects a normally closed alarm contact, active when it opens
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) fire_alarm_active <= 1'b0;
    else fire_alarm_active <= lvl_reg[SUS_FIRE] ^ lvl_reg[SUS_FIRE_POL];  // see RULE5
  end

  // ****************************************
  // single passage grants
  // ****************************************
  grant_e          grant_reg [2];
  logic [MS_W-1:0] grant_ms_reg [2];
  logic [1:0]      grant_req, pass_done;

  assign grant_req[0] = (mom_fire_reg[MOM_GOOD_ENT] || mom_fire_reg[MOM_OVR_ENT])
                        && entry_mode != MODE_CLOSED;
  assign grant_req[1] = mom_fire_reg[MOM_GOOD_EXT];
  assign pass_done    = {exit_pass_done, entry_pass_done};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < 2; d++) begin
        grant_reg[d]    <= GRANT_IDLE;
        grant_ms_reg[d] <= '0;
      end
    end else begin
      for (int d = 0; d < 2; d++) begin
        unique case (grant_reg[d])
          GRANT_IDLE: begin
            if (grant_req[d]) begin
              grant_reg[d]    <= GRANT_OPEN;  // see RULE6 see RULE10
              grant_ms_reg[d] <= MS_W'(GRANT_TIMEOUT_MS);
            end
          end
          GRANT_OPEN: begin
            grant_ms_reg[d] <= count_down(grant_ms_reg[d], tick_reg);
            if (pass_done[d] || grant_ms_reg[d] == '0) grant_reg[d] <= GRANT_IDLE;  // see RULE6
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_unlock <= 1'b0;
      exit_unlock  <= 1'b0;
    end else begin
      entry_unlock <= grant_reg[0] == GRANT_OPEN || entry_mode == MODE_FREE;
      exit_unlock  <= grant_reg[1] == GRANT_OPEN || exit_free;
    end
  end

  // ****************************************
  // output contacts
  // ****************************************
  logic [N_OUT-1:0] ev;
  logic [N_OUT-1:0] out_reg;
  logic [MS_W-1:0]  out_ms_reg [N_OUT];
  logic             ent_ok, ext_ok;

  assign ent_ok = grant_reg[0] == GRANT_OPEN || entry_mode == MODE_FREE;
  assign ext_ok = grant_reg[1] == GRANT_OPEN || exit_free;
  assign ev[OUT_AUTH_ENT]   = entry_pass_done && ent_ok;  // see RULE12
  assign ev[OUT_UNAUTH_ENT] = entry_pass_done && !ent_ok;  // see RULE13
  assign ev[OUT_INTR_ENT]   = entry_lane_intrude && !ent_ok;  // see RULE14
  assign ev[OUT_AUTH_EXT]   = exit_pass_done && ext_ok;  // see RULE15
  assign ev[OUT_UNAUTH_EXT] = exit_pass_done && !ext_ok;  // see RULE16

  // a new event restarts the contact, so two close passages merge into one long closure
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_reg <= '0;
      for (int i = 0; i < N_OUT; i++) out_ms_reg[i] <= '0;
    end else begin
      for (int i = 0; i < N_OUT; i++) begin
        if (ev[i]) begin
          out_ms_reg[i] <= MS_W'(OUT_PULSE_MS);  // see RULE4
          out_reg[i]    <= 1'b1;
        end else begin
          out_ms_reg[i] <= count_down(out_ms_reg[i], tick_reg);
          out_reg[i]    <= !(tick_reg && out_ms_reg[i] <= MS_W'(1)) && out_ms_reg[i] != '0;
        end
      end
    end
  end

  assign authorized_entry_out   = out_reg[OUT_AUTH_ENT];
  assign unauthorized_entry_out = out_reg[OUT_UNAUTH_ENT];
  assign entry_intrusion_out    = out_reg[OUT_INTR_ENT];
  assign authorized_exit_out    = out_reg[OUT_AUTH_EXT];
  assign unauthorized_exit_out  = out_reg[OUT_UNAUTH_EXT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) reserved_contacts_out <= '0;
    else reserved_contacts_out <= '0;  // see RULE18
  end

  // ****************************************
  // entry red lamp
  // ****************************************
  logic [MS_W-1:0] red_ms_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      red_ms_reg     <= '0;
      entry_red_lamp <= 1'b0;
    end else if (mom_fire_reg[MOM_BAD_ENT]) begin
      red_ms_reg     <= MS_W'(RED_LAMP_MS);  // see RULE7
      entry_red_lamp <= 1'b1;
    end else begin
      red_ms_reg     <= count_down(red_ms_reg, tick_reg);
      entry_red_lamp <= !(tick_reg && red_ms_reg <= MS_W'(1)) && red_ms_reg != '0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_entry_req;
    grant_reg[0] == GRANT_IDLE && grant_req[0];
  endsequence

  sequence s_entry_pass;
    grant_reg[0] == GRANT_OPEN && entry_pass_done;
  endsequence

  // only the bits that moved are held to agreement; other pins may be mid-sync
  a_sync_agree: assert property (@(posedge clk) disable iff (!resetn) // see RULE17
    ((lvl_reg ^ $past(lvl_reg)) & ($past(s2_reg) ^ $past(s3_reg))) == '0)
    else $error("level changed while sync stages disagreed");
  a_min_closure: assert property (@(posedge clk) disable iff (!resetn) // see RULE2
    mom_fire_reg[MOM_GOOD_ENT] |-> hold_ms_reg[MOM_GOOD_ENT] == MS_W'(MIN_CLOSE_MS + 1))
    else $error("momentary input accepted before 100 ms");
  a_fire_once: assert property (@(posedge clk) disable iff (!resetn) // see RULE3
    mom_fire_reg[MOM_GOOD_EXT] |=> !mom_fire_reg[MOM_GOOD_EXT] [*8])
    else $error("one closure accepted twice");
  a_out_start: assert property (@(posedge clk) disable iff (!resetn) // see RULE4
    ev[OUT_AUTH_ENT] |=> authorized_entry_out && out_ms_reg[OUT_AUTH_ENT] == MS_W'(OUT_PULSE_MS))
    else $error("output pulse not started at full length");
  a_out_end: assert property (@(posedge clk) disable iff (!resetn) // see RULE4
    $fell(authorized_exit_out) |-> $past(out_ms_reg[OUT_AUTH_EXT]) == MS_W'(1) && $past(tick_reg))
    else $error("output pulse ended early");
  a_fire_polarity: assert property (@(posedge clk) disable iff (!resetn) // see RULE5
    (lvl_reg[SUS_FIRE] == lvl_reg[SUS_FIRE_POL]) [*2] |-> !fire_alarm_active)
    else $error("fire alarm active with contact at rest");
  a_grant_opens: assert property (@(posedge clk) disable iff (!resetn) // see RULE6 RULE10
    s_entry_req |=> grant_reg[0] == GRANT_OPEN ##1 entry_unlock)
    else $error("entry grant not opened");
  a_grant_ends: assert property (@(posedge clk) disable iff (!resetn) // see RULE6
    s_entry_pass |=> grant_reg[0] == GRANT_IDLE)
    else $error("entry grant outlived its passage");
  a_red_lamp: assert property (@(posedge clk) disable iff (!resetn) // see RULE7
    mom_fire_reg[MOM_BAD_ENT] |=> entry_red_lamp && red_ms_reg == MS_W'(RED_LAMP_MS))
    else $error("red lamp not lit for bad card");
  a_free_entry: assert property (@(posedge clk) disable iff (!resetn) // see RULE8
    lvl_reg[SUS_FREE_ENT] && !lvl_reg[SUS_CLOSE_ENT] |=> entry_mode == MODE_FREE)
    else $error("entry free passage not applied");
  a_closed_entry: assert property (@(posedge clk) disable iff (!resetn) // see RULE9
    lvl_reg[SUS_CLOSE_ENT] && !lvl_reg[SUS_VISITOR] |=> entry_mode == MODE_CLOSED)
    else $error("entry no passage not applied");
  a_visitor_mode: assert property (@(posedge clk) disable iff (!resetn) // see RULE11
    lvl_reg[SUS_VISITOR] |=> exit_free && barrier_disable && entry_mode == MODE_FREE)
    else $error("visitor mode not applied");
  a_auth_entry: assert property (@(posedge clk) disable iff (!resetn) // see RULE12
    s_entry_pass |=> authorized_entry_out && !$rose(unauthorized_entry_out))
    else $error("authorized entry not reported");
  a_unauth_entry: assert property (@(posedge clk) disable iff (!resetn) // see RULE13
    entry_pass_done && !ent_ok |=> unauthorized_entry_out)
    else $error("unauthorized entry not reported");
  a_intrusion: assert property (@(posedge clk) disable iff (!resetn) // see RULE14
    entry_lane_intrude && !ent_ok |=> entry_intrusion_out)
    else $error("entry intrusion not reported");
  a_auth_exit: assert property (@(posedge clk) disable iff (!resetn) // see RULE15
    exit_pass_done && ext_ok |=> authorized_exit_out && !$rose(unauthorized_exit_out))
    else $error("authorized exit not reported");
  a_unauth_exit: assert property (@(posedge clk) disable iff (!resetn) // see RULE16
    exit_pass_done && !ext_ok |=> unauthorized_exit_out && !$rose(authorized_exit_out))
    else $error("unauthorized exit not reported");
  a_reserved_open: assert property (@(posedge clk) disable iff (!resetn) // see RULE18
    reserved_contacts_out == '0)
    else $error("reserved contact closed");

endmodule

// *** testbench/access_ctrl_model.sv ***
module access_ctrl_model
  import turnstile_contact_pkg::*;
#(
  parameter int TICK = 4
) (
  input  wire logic             clk,
  output logic      [N_PIN-1:0] contact
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // dry contacts, open when idle
  // ****************************************
  initial contact = PIN_RESET;

  // momentary closure in whole ms; callers keep 100 ms..2 s unless testing a refusal
  task automatic press(input int idx, input int ms);
    @(posedge clk);
    #1 contact[idx] = 1'b1;
    repeat (ms * TICK) @(posedge clk);
    #1 contact[idx] = 1'b0;
  endtask

  // sustained level; fire alarm may idle closed, so any level is allowed
  task automatic hold(input int idx, input logic lvl);
    @(posedge clk);
    #1 contact[idx] = lvl;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** testbench/tb_turnstile_contact_io.sv ***
module tb_turnstile_contact_io
  import turnstile_contact_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 4;

  logic             clk;
  logic             resetn;
  logic [N_PIN-1:0] pin;
  logic [2:0]       lane_v;
  logic [N_OUT-1:0] outs;
  logic [N_RESV-1:0] resv;
  logic             entry_unlock;
  logic             exit_unlock;
  logic             entry_red_lamp;
  dir_mode_e        entry_mode;
  logic             exit_free;
  logic             barrier_disable;
  logic             fire_alarm_active;
  logic [5:0]       mon;
  int               bad_count;
  int               checks;
  int               len [6];
  int               exp_q[$];
  int               ms;

  access_ctrl_model #(.TICK(T)) pm (.clk(clk), .contact(pin));

  turnstile_contact_io #(.TICK_CYCLES(T)) dut_u (
    .clk(clk), .resetn(resetn),
    .good_card_entry_in(pin[MOM_GOOD_ENT]), .good_card_exit_in(pin[MOM_GOOD_EXT]),
    .bad_card_entry_in(pin[MOM_BAD_ENT]), .single_override_entry_in(pin[MOM_OVR_ENT]),
    .free_passage_entry_in(pin[SUS_FREE_ENT]), .close_entry_in(pin[SUS_CLOSE_ENT]),
    .visitor_mode_in(pin[SUS_VISITOR]), .fire_alarm_in(pin[SUS_FIRE]),
    .fire_alarm_polarity_jumper(pin[SUS_FIRE_POL]),
    .entry_pass_done(lane_v[0]), .exit_pass_done(lane_v[1]), .entry_lane_intrude(lane_v[2]),
    .authorized_entry_out(outs[OUT_AUTH_ENT]), .unauthorized_entry_out(outs[OUT_UNAUTH_ENT]),
    .entry_intrusion_out(outs[OUT_INTR_ENT]), .authorized_exit_out(outs[OUT_AUTH_EXT]),
    .unauthorized_exit_out(outs[OUT_UNAUTH_EXT]), .reserved_contacts_out(resv),
    .entry_unlock(entry_unlock), .exit_unlock(exit_unlock), .entry_red_lamp(entry_red_lamp),
    .entry_mode(entry_mode), .exit_free(exit_free), .barrier_disable(barrier_disable),
    .fire_alarm_active(fire_alarm_active)
  );

  assign mon = {entry_red_lamp, outs};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one-cycle lane pulse; id is the contact expected to answer, 7 for none
  task automatic lane(input int sel, input int id);
    @(posedge clk);
    #1 lane_v[sel] = 1'b1;
    if (id != 7) exp_q.push_back(id);
    @(posedge clk);
    #1 lane_v[sel] = 1'b0;
  endtask

  // ****************************************
  // scoreboard: a closure is matched to the oldest note as it rises, timed on release
  // ****************************************
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (mon[i] === 1'b1) begin
        // matching on the rise keeps the long red lamp from overtaking later notes
        if (len[i] == 0) check(i, exp_q.size() ? exp_q.pop_front() : 32'hff);
        len[i]++;
      end else if (len[i] != 0) begin
        ms = (i == 5) ? RED_LAMP_MS : OUT_PULSE_MS;
        // the tick divider free-runs, so up to one ms of slack at the start
        check(len[i] >= (ms - 1) * T && len[i] <= ms * T + 2, 1'b1);
        len[i] = 0;
      end
    end
  end

  initial begin
    #2000000;
    bad_count++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    lane_v = 3'h0;
    ms = $urandom(44519);
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    check({mon, resv}, 9'h000);
    check(entry_mode, MODE_CONTROLLED);
    pm.press(MOM_GOOD_ENT, 90);
    repeat (20) @(posedge clk);
    check(entry_unlock, 1'b0);
    // ****************************************
    // momentary grants and passage reports
    // ****************************************
    pm.press(MOM_GOOD_ENT, $urandom_range(1000, 110));
    check(entry_unlock, 1'b1);
    lane(2, 7);
    lane(0, OUT_AUTH_ENT);
    repeat (3) @(posedge clk);
    check(entry_unlock, 1'b0);
    lane(0, OUT_UNAUTH_ENT);
    lane(2, OUT_INTR_ENT);
    pm.press(MOM_GOOD_EXT, $urandom_range(1000, 110));
    check(exit_unlock, 1'b1);
    lane(1, OUT_AUTH_EXT);
    lane(1, OUT_UNAUTH_EXT);
    exp_q.push_back(5);
    pm.press(MOM_BAD_ENT, 150);
    check(entry_red_lamp, 1'b1);
    pm.press(MOM_OVR_ENT, 150);
    check(entry_unlock, 1'b1);
    lane(0, OUT_AUTH_ENT);
    repeat (1300) @(posedge clk);
    pm.press(MOM_GOOD_ENT, 2000);
    check(entry_unlock, 1'b1);
    lane(0, OUT_AUTH_ENT);
    repeat (1300) @(posedge clk);
    // ****************************************
    // sustained modes and fire alarm
    // ****************************************
    pm.hold(SUS_FREE_ENT, 1'b1);
    check({entry_mode, entry_unlock}, {MODE_FREE, 1'b1});
    lane(2, 7);
    lane(0, OUT_AUTH_ENT);
    pm.hold(SUS_CLOSE_ENT, 1'b1);
    check(entry_mode, MODE_CLOSED);
    pm.press(MOM_GOOD_ENT, 110);
    check(entry_unlock, 1'b0);
    pm.hold(SUS_VISITOR, 1'b1);
    check({exit_free, barrier_disable, exit_unlock}, 3'h7);
    pm.hold(SUS_VISITOR, 1'b0);
    pm.hold(SUS_CLOSE_ENT, 1'b0);
    pm.hold(SUS_FREE_ENT, 1'b0);
    check({entry_mode, exit_free, barrier_disable}, {MODE_CONTROLLED, 2'h0});
    pm.hold(SUS_FIRE, 1'b1);
    check(fire_alarm_active, 1'b1);
    pm.hold(SUS_FIRE_POL, 1'b1);
    check(fire_alarm_active, 1'b0);
    pm.hold(SUS_FIRE, 1'b0);
    check(fire_alarm_active, 1'b1);
    pm.hold(SUS_FIRE_POL, 1'b0);
    check(fire_alarm_active, 1'b0);
    // an exit grant with no passage must lapse after the grant timeout
    pm.press(MOM_GOOD_EXT, 110);
    repeat (19900) @(posedge clk);
    check(exit_unlock, 1'b1);
    repeat (200) @(posedge clk);
    check(exit_unlock, 1'b0);
    check(exp_q.size(), 0);
    check(resv, 3'h0);
    end_of_test();
  end
endmodule
